// >>> rtl/bocr_map.vh
/*
 * Register map, field positions, reset values and timing counts for the bias, oscillator,
 * output divider and output driver register bank.
 * Assumes a single 25 MHz device clock; included by bare name from the design files.
 */
`ifndef BOCR_MAP_VH
`define BOCR_MAP_VH

// register indexes on the internal register port
`define BOCR_IDX_CAL_STATUS 4'h0
`define BOCR_IDX_OSC_CFG 4'h1
`define BOCR_IDX_DIV_CFG 4'h2
`define BOCR_IDX_DRV_EN 4'h3
`define BOCR_IDX_DRV_MODE 4'h4

// bias calibration status fields
`define BOCR_BS_DONE 0
`define BOCR_BS_FAIL 1
`define BOCR_BS_CODE_LO 2
`define BOCR_BS_CODE_HI 4
`define BOCR_BS_EFF_LO 5
`define BOCR_BS_EFF_HI 7
`define BOCR_BS_CMP 8

// oscillator config fields and reset
`define BOCR_OSC_XIN_LO 0
`define BOCR_OSC_XIN_HI 5
`define BOCR_OSC_RSV_LO 6
`define BOCR_OSC_RSV_HI 7
`define BOCR_OSC_XOUT_LO 8
`define BOCR_OSC_XOUT_HI 13
`define BOCR_OSC_BOOST_LO 14
`define BOCR_OSC_BOOST_HI 15
`define BOCR_OSC_REG_ON 16
`define BOCR_OSC_SPARE_LO 17
`define BOCR_OSC_SPARE_HI 18
`define BOCR_OSC_WMASK 32'h0007ffff
`define BOCR_OSC_RESET 32'h00015f1f
`define BOCR_CAP_MAX 6'h2f

// output divider config fields and reset
`define BOCR_DIV_RATIO_LO 0
`define BOCR_DIV_RATIO_HI 13
`define BOCR_DIV_REG_ON 15
`define BOCR_DIV_WMASK 16'hbfff
`define BOCR_DIV_RESET 16'h8069
`define BOCR_DIV_MIN 14'h000a

// output driver enable fields and reset
`define BOCR_DRV_PD 0
`define BOCR_DRV_FORCE_OFF 1
`define BOCR_DRV_DIS_LO 2
`define BOCR_DRV_DIS_HI 3
`define BOCR_DRV_WMASK 8'h0f
`define BOCR_DRV_RESET 8'h00

// driver type field and codes
`define BOCR_MODE_LO 0
`define BOCR_MODE_HI 1
`define BOCR_MODE_RESET 2'h0
`define BOCR_TYPE_HCSL 2'h0
`define BOCR_TYPE_LVDS 2'h2
`define BOCR_TYPE_CMOS 2'h3

// disabled-level codes
`define BOCR_DIS_LOW_LOW 2'h0
`define BOCR_DIS_LOW_HIGH 2'h1
`define BOCR_DIS_HIZ 2'h2
`define BOCR_DIS_RUN 2'h3

// calibration timing: settle time per step in ns, clock period in ns
`define BOCR_CLK_PERIOD_NS 40
`define BOCR_CAL_SETTLE_NS 1000
`define BOCR_CAL_SETTLE_CYC ((`BOCR_CAL_SETTLE_NS + `BOCR_CLK_PERIOD_NS - 1) / `BOCR_CLK_PERIOD_NS)
`define BOCR_CAL_FALLBACK 3'h4

`endif

// >>> rtl/bocr_bias_cal.v
/*
 * Bias calibration sequencer: a three-step successive approximation of the bias trim code
 * against the calibration comparator, started once by reset release.
 * Assumes the comparator input is synchronous to mclk and settles within the settle time.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bocr_map.vh"

module bocr_bias_cal (
   // clock and reset
   input wire mclk,
   input wire rst,
   // comparator and results
   input wire cmp_in,
   output reg done_q,
   output reg fail_q,
   output reg [2:0] code_q,
   output reg [2:0] eff_q
);

   localparam ST_SETTLE = 2'h0;
   localparam ST_DECIDE = 2'h1;
   localparam ST_DONE = 2'h2;
   localparam integer SETTLE_INT = `BOCR_CAL_SETTLE_CYC;
   localparam [5:0] SETTLE_CYC = SETTLE_INT[5:0];

   reg [1:0] state_q;
   reg [5:0] wait_q;
   reg [2:0] trial_q;
   reg [2:0] bit_q;

   // one trial bit per step, msb first; comparator high means the trim is too low
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= ST_SETTLE;
         wait_q <= 6'h00;
         trial_q <= 3'h4;
         bit_q <= 3'h4;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         code_q <= 3'h0;
         eff_q <= 3'h0;
      end else begin
         case (state_q)
            ST_SETTLE: begin
               if (wait_q == SETTLE_CYC - 6'h01) begin
                  wait_q <= 6'h00;
                  state_q <= ST_DECIDE;
               end else begin
                  wait_q <= wait_q + 6'h01;
               end
            end
            ST_DECIDE: begin
               if (bit_q == 3'h1) begin
                  // a code pinned at either end means the loop never crossed the target
                  code_q <= cmp_in ? trial_q : (trial_q & ~bit_q);
                  fail_q <= cmp_in ? (trial_q == 3'h7) : ((trial_q & ~bit_q) == 3'h0);
                  eff_q <= (cmp_in ? (trial_q == 3'h7) : ((trial_q & ~bit_q) == 3'h0)) ?
                           `BOCR_CAL_FALLBACK : (cmp_in ? trial_q : (trial_q & ~bit_q));
                  done_q <= 1'b1;
                  state_q <= ST_DONE;
               end else begin
                  trial_q <= (cmp_in ? trial_q : (trial_q & ~bit_q)) | (bit_q >> 1);
                  bit_q <= bit_q >> 1;
                  state_q <= ST_SETTLE;
               end
            end
            ST_DONE: begin
               state_q <= ST_DONE; // results hold until the next reset
            end
            default: begin
               state_q <= ST_SETTLE;
            end
         endcase
      end
   end

endmodule // bocr_bias_cal
`default_nettype wire

// >>> rtl/bocr_regs.v
/*
 * Register bank for bias calibration status, crystal oscillator control, output divider
 * control and output driver enable/type, plus the output pair's enable and level logic.
 * Assumes a simple synchronous register port driven by the serial processor port logic,
 * one 25 MHz clock, and a divided clock level arriving from the output divider.
 * The register port strobes are single-cycle pulses; read data follow one cycle later.
 * The analog side acts on the regulator, boost, capacitance and trim outputs directly,
 * and the pad ring turns the pin levels and enables into the real output pair.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bocr_map.vh"

// Overview of operation
// - calibration-complete reads 0 while bias calibration runs and 1 once it has finished.
// - calibration-failed reads 1 if calibration did not succeed, valid once complete is 1.
// - bits 4:2 of the bias status report the trim code the calibration logic picked.
// - bits 7:5 of the bias status report the trim code delivered to the bias circuit.
// - bias status bit 8 shows the raw calibration comparator at the time of the read.
// - oscillator bits 15:14 choose none, one, two or all three startup boost amplifiers.
// - the input-pin capacitance code adds 0.5pF per step up to 0x2F, higher codes reserved.
// - the output-pin capacitance code works the same way, with codes above 0x2F reserved.
// - oscillator bit 16 switches the oscillator regulator on when set and off when clear.
// - divider bit 15 switches the divider regulator on when set and off when clear.
// - bits 3:2 pick the disabled level: low/low (low/high for LVDS), low/high, hi-z, toggle.
// - force-off bit 1 disables the driver; clear, the driver runs unless disabled otherwise.
// - power-down bit 0 powers the driver down, tri-states both pins, ignores output enable.
// - the driver type field selects HCSL, reserved, LVDS or CMOS, steering the LVDS low/low and CMOS in-phase cases.
module bocr_regs (
   // clock and reset
   input wire mclk,
   input wire rst,
   // register port
   input wire [3:0] reg_addr,
   input wire reg_wr,
   input wire [31:0] reg_wdata,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   output reg reg_rvalid,
   // bias calibration comparator
   input wire bias_cmp_in,
   output wire [2:0] bias_trim_code,
   // crystal oscillator controls
   output wire osc_regulator_on,
   output wire [2:0] osc_boost_amp_en,
   output wire [5:0] osc_cap_xin,
   output wire [5:0] osc_cap_xout,
   output wire [1:0] osc_spare_bits,
   // output divider controls
   output wire divider_regulator_on,
   output wire [13:0] divider_ratio,
   output wire divider_ratio_bad,
   // output driver
   input wire divided_clk,
   input wire ext_disable,
   output wire driver_powerdown,
   output wire [1:0] driver_type,
   output reg driver_active,
   output reg out_p,
   output reg out_p_oe,
   output reg out_n,
   output reg out_n_oe
);

   // capacitance codes above the top step are reserved; flag them for the analog side
   function cap_code_ok;
      input [5:0] code;
      begin
         cap_code_ok = (code <= `BOCR_CAP_MAX);
      end
   endfunction

   // complementary pin level while running; cmos drives both pins in phase
   function run_n_level;
      input [1:0] drv_type;
      input clk_level;
      begin
         run_n_level = (drv_type == `BOCR_TYPE_CMOS) ? clk_level : !clk_level;
      end
   endfunction

   // lvds cannot sit at low/low, so the first disabled level becomes low/high there
   function lowlow_n_level;
      input [1:0] drv_type;
      begin
         lowlow_n_level = (drv_type == `BOCR_TYPE_LVDS);
      end
   endfunction

   // internal decode, status and pin-level nets
   wire cal_done;
   wire cal_fail;
   wire [2:0] cal_code;
   wire [2:0] cal_eff;
   wire wr_osc;
   wire wr_div;
   wire wr_drv;
   wire wr_mode;
   wire pd;
   wire force_off;
   wire [1:0] dis_state;
   wire disabled;
   wire [31:0] bias_word;
   wire run_n;
   wire ratio_low;
   wire xin_bad;
   wire xout_bad;

   // register state and next-state terms
   reg [31:0] osc_q;
   reg [15:0] div_q;
   reg [7:0] drv_q;
   reg [1:0] mode_q;
   reg [31:0] rd_d;
   reg p_d;
   reg p_oe_d;
   reg n_d;
   reg n_oe_d;
   reg active_d;

   // bias calibration engine, started by reset release
   // the calibration restarts only on reset; software cannot retrigger it
   bocr_bias_cal u_cal (
      .mclk(mclk),
      .rst(rst),
      .cmp_in(bias_cmp_in),
      .done_q(cal_done),
      .fail_q(cal_fail),
      .code_q(cal_code),
      .eff_q(cal_eff)
   );

   // delivered trim goes straight to the bias control circuit
   assign bias_trim_code = cal_eff;

   // write decode per register
   // the status index takes no write; unmapped indexes fall through and are ignored
   assign wr_osc = reg_wr && (reg_addr == `BOCR_IDX_OSC_CFG);
   assign wr_div = reg_wr && (reg_addr == `BOCR_IDX_DIV_CFG);
   assign wr_drv = reg_wr && (reg_addr == `BOCR_IDX_DRV_EN);
   assign wr_mode = reg_wr && (reg_addr == `BOCR_IDX_DRV_MODE);

   // writable registers; masks keep read-only reserved bits at zero
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         osc_q <= `BOCR_OSC_RESET;
         div_q <= `BOCR_DIV_RESET;
         drv_q <= `BOCR_DRV_RESET;
         mode_q <= `BOCR_MODE_RESET;
      end else begin
         if (wr_osc) begin
            // bits 7:6 stay writable though unused; only 31:19 are forced to zero
            osc_q <= reg_wdata & `BOCR_OSC_WMASK;
         end
         if (wr_div) begin
            div_q <= reg_wdata[15:0] & `BOCR_DIV_WMASK;
         end
         if (wr_drv) begin
            drv_q <= reg_wdata[7:0] & `BOCR_DRV_WMASK;
         end
         if (wr_mode) begin
            mode_q <= reg_wdata[`BOCR_MODE_HI:`BOCR_MODE_LO];
         end
      end
   end

   // oscillator controls
   assign osc_regulator_on = osc_q[`BOCR_OSC_REG_ON];
   assign osc_cap_xin = osc_q[`BOCR_OSC_XIN_HI:`BOCR_OSC_XIN_LO];
   assign osc_cap_xout = osc_q[`BOCR_OSC_XOUT_HI:`BOCR_OSC_XOUT_LO];
   assign osc_spare_bits = osc_q[`BOCR_OSC_SPARE_HI:`BOCR_OSC_SPARE_LO];

   // boost code turns on that many parallel amplifiers, thermometer style
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_boost
         assign osc_boost_amp_en[gi] =
            (osc_q[`BOCR_OSC_BOOST_HI:`BOCR_OSC_BOOST_LO] > gi);
      end
   endgenerate

   // divider controls; a ratio under the minimum is software's fault, only reported here
   assign divider_regulator_on = div_q[`BOCR_DIV_REG_ON];
   assign divider_ratio = div_q[`BOCR_DIV_RATIO_HI:`BOCR_DIV_RATIO_LO];
   assign ratio_low = (divider_ratio < `BOCR_DIV_MIN);

   // reserved capacitance codes are stored as written and only flagged, never clipped
   assign xin_bad = !cap_code_ok(osc_cap_xin);
   assign xout_bad = !cap_code_ok(osc_cap_xout);
   // one flag for a low ratio or a reserved capacitance code; the separate nets show which field caused it
   assign divider_ratio_bad = ratio_low || xin_bad || xout_bad;

   // driver enable fields
   assign pd = drv_q[`BOCR_DRV_PD];
   assign force_off = drv_q[`BOCR_DRV_FORCE_OFF];
   assign dis_state = drv_q[`BOCR_DRV_DIS_HI:`BOCR_DRV_DIS_LO];
   assign disabled = force_off || ext_disable;
   assign driver_powerdown = pd;
   assign driver_type = mode_q;

   // complementary pin level while the pair runs, shared by normal and debug operation
   assign run_n = run_n_level(mode_q, divided_clk);

   // status word: comparator is sampled live, reserved bits read zero
   assign bias_word = {23'h000000,
                       bias_cmp_in,
                       cal_eff,
                       cal_code,
                       cal_fail,
                       cal_done};

   // read mux; unmapped indexes read zero
   // a read and a write in the same cycle return the value held before the write
   always @* begin
      case (reg_addr)
         `BOCR_IDX_CAL_STATUS: rd_d = bias_word;
         `BOCR_IDX_OSC_CFG: rd_d = osc_q;
         `BOCR_IDX_DIV_CFG: rd_d = {16'h0000, div_q};
         `BOCR_IDX_DRV_EN: rd_d = {24'h000000, drv_q};
         `BOCR_IDX_DRV_MODE: rd_d = {30'h00000000, mode_q};
         default: rd_d = 32'h00000000;
      endcase
   end

   // read data registered, valid one cycle after the read strobe
   // rdata holds between reads, so a late look at it still sees the last answer
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_d;
         end
      end
   end

   // output pair next state: power-down wins over every enable source
   always @* begin
      p_d = 1'b0;
      n_d = 1'b0;
      p_oe_d = 1'b0;
      n_oe_d = 1'b0;
      active_d = 1'b0;
      if (pd) begin
         // both pins tri-stated, enable controls ignored
         p_oe_d = 1'b0;
         n_oe_d = 1'b0;
      end else if (!disabled) begin
         // enabled: the pair follows the divided clock
         active_d = 1'b1;
         p_oe_d = 1'b1;
         n_oe_d = 1'b1;
         p_d = divided_clk;
         n_d = run_n;
      end else begin
         case (dis_state)
            `BOCR_DIS_LOW_LOW: begin
               p_oe_d = 1'b1;
               n_oe_d = 1'b1;
               n_d = lowlow_n_level(mode_q); // lvds holds low/high
            end
            `BOCR_DIS_LOW_HIGH: begin
               p_oe_d = 1'b1;
               n_oe_d = 1'b1;
               n_d = 1'b1;
            end
            `BOCR_DIS_HIZ: begin
               p_oe_d = 1'b0;
               n_oe_d = 1'b0;
            end
            default: begin
               // debug only: keeps toggling although nominally disabled
               p_oe_d = 1'b1;
               n_oe_d = 1'b1;
               p_d = divided_clk;
               n_d = run_n;
            end
         endcase
      end
   end

   // pins come from flops so a register write never glitches the pair
   // limitation: the pair lags divided_clk by one mclk, so it cannot toggle above mclk/2
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         out_p <= 1'b0;
         out_n <= 1'b0;
         out_p_oe <= 1'b0;
         out_n_oe <= 1'b0;
         driver_active <= 1'b0;
      end else begin
         out_p <= p_d;
         out_n <= n_d;
         out_p_oe <= p_oe_d;
         out_n_oe <= n_oe_d;
         driver_active <= active_d;
      end
   end

endmodule // bocr_regs
`default_nettype wire

// >>> test/bocr_regs_asserts.sv
/* checker for bocr_regs: register port answers, oscillator and divider controls, pins.
   assumes one mclk domain and rst active high, asynchronous. */
`timescale 1ns/1ps
`default_nettype none
module bocr_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // device side
   input wire logic bias_cmp_in,
   input wire logic osc_regulator_on,
   input wire logic [2:0] osc_boost_amp_en,
   input wire logic divider_regulator_on,
   input wire logic driver_powerdown,
   input wire logic out_p,
   input wire logic out_p_oe,
   input wire logic out_n,
   input wire logic out_n_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // driver-enable write not overwritten in the next cycle, so pins settle to it
   sequence s_drv(logic [3:0] v);
      reg_wr && reg_addr == 4'h3 && reg_wdata[3:0] == v ##1 !(reg_wr && reg_addr == 4'h3);
   endsequence
   chk_cmp_raw: assert property (reg_rd && reg_addr == 4'h0
      |=> reg_rdata[8] == $past(bias_cmp_in))
      else $error("raw comparator bit wrong");
   chk_status_rsvd: assert property (reg_rd && reg_addr == 4'h0
      |=> reg_rdata[31:9] == 23'h0)
      else $error("status reserved bits not zero");
   chk_unmapped_zero: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_osc_reg: assert property (reg_wr && reg_addr == 4'h1
      |=> osc_regulator_on == $past(reg_wdata[16]))
      else $error("osc regulator not following write");
   chk_boost_count: assert property (reg_wr && reg_addr == 4'h1
      |=> osc_boost_amp_en == (3'h7 >> (2'd3 - $past(reg_wdata[15:14]))))
      else $error("boost amplifier count wrong");
   chk_div_reg: assert property (reg_wr && reg_addr == 4'h2
      |=> divider_regulator_on == $past(reg_wdata[15]))
      else $error("divider regulator not following write");
   chk_pd_hiz: assert property (driver_powerdown |=> !out_p_oe && !out_n_oe)
      else $error("pins driven while powered down");
   chk_force_hiz: assert property (s_drv(4'ha) |=> !out_p_oe && !out_n_oe)
      else $error("forced off hi-z pins driven");
   chk_dis_lowhigh: assert property (s_drv(4'h6) |=> out_p_oe && out_n_oe && !out_p && out_n)
      else $error("disabled low/high level wrong");
   // main scenarios reached
   cover property (s_drv(4'h6));
   cover property (reg_rd && reg_addr == 4'h0);
   cover property (driver_powerdown ##1 !driver_powerdown);
endmodule // bocr_chk
bind bocr_regs bocr_chk i_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bias_cmp_in(bias_cmp_in),
   .osc_regulator_on(osc_regulator_on), .osc_boost_amp_en(osc_boost_amp_en),
   .divider_regulator_on(divider_regulator_on), .driver_powerdown(driver_powerdown),
   .out_p(out_p), .out_p_oe(out_p_oe), .out_n(out_n), .out_n_oe(out_n_oe));
`default_nettype wire

// >>> test/tb_top.sv
/* self-checking bench for bocr_regs: calibration, register map and output pin levels.
   assumes the design header is on the include path; drives every input itself. */
`timescale 1ns/1ps
`default_nettype none
`include "bocr_map.vh"
module tb_top;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic bias_cmp_in = 1'b1;
   logic divided_clk = 1'b1;
   logic ext_disable = 1'b0;
   logic [31:0] reg_rdata, rv;
   logic [13:0] divider_ratio;
   logic [5:0] osc_cap_xin, osc_cap_xout;
   logic [2:0] bias_trim_code, osc_boost_amp_en;
   logic [1:0] osc_spare_bits, driver_type;
   logic reg_rvalid, osc_regulator_on, divider_regulator_on, divider_ratio_bad;
   logic driver_powerdown, driver_active, out_p, out_p_oe, out_n, out_n_oe;
   int n_fail = 0;
   int tests_run = 0;
   int i, t, c;
   bocr_regs i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .bias_cmp_in(bias_cmp_in), .bias_trim_code(bias_trim_code),
      .osc_regulator_on(osc_regulator_on), .osc_boost_amp_en(osc_boost_amp_en),
      .osc_cap_xin(osc_cap_xin), .osc_cap_xout(osc_cap_xout), .osc_spare_bits(osc_spare_bits),
      .divider_regulator_on(divider_regulator_on), .divider_ratio(divider_ratio),
      .divider_ratio_bad(divider_ratio_bad), .divided_clk(divided_clk),
      .ext_disable(ext_disable), .driver_powerdown(driver_powerdown),
      .driver_type(driver_type), .driver_active(driver_active), .out_p(out_p),
      .out_p_oe(out_p_oe), .out_n(out_n), .out_n_oe(out_n_oe));
   // 25 MHz clock
   always #20 mclk = ~mclk;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // read strobe one cycle; answer taken just after the edge that raises rvalid
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk("rvalid", 32'h1, reg_rvalid);
      rv = reg_rdata;
   endtask
   // register then pin stage both land
   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // comparator high, mid for the second step window, high again; decisions near 26/52/78
   task automatic t_cal(input logic mid, input logic [2:0] code, input logic f,
      input logic [2:0] eff);
      @(posedge mclk);
      rst <= 1'b1;
      bias_cmp_in <= 1'b1;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rd(4'h0);
      chk("busy", 32'h0, rv[0]);
      repeat (36) @(posedge mclk);
      bias_cmp_in <= mid;
      repeat (26) @(posedge mclk);
      bias_cmp_in <= 1'b1;
      for (i = 0; i < 100 && rv[0] !== 1'b1; i++) rd(4'h0);
      chk("done", 32'h1, rv[0]);
      chk("fail", f, rv[1]);
      chk("picked", code, rv[4:2]);
      chk("eff", eff, rv[7:5]);
      chk("trim", eff, bias_trim_code);
      bias_cmp_in <= 1'b0;
      rd(4'h0);
      chk("hold", {23'h0, 1'b0, eff, code, f, 1'b1}, rv);
      bias_cmp_in <= 1'b1;
      $display("t_cal done");
   endtask
   task automatic t_reset;
      rd(4'h1);
      chk("osc rst", `BOCR_OSC_RESET, rv);
      rd(4'h2);
      chk("div rst", `BOCR_DIV_RESET, rv);
      rd(4'h3);
      chk("drv rst", `BOCR_DRV_RESET, rv);
      rd(4'h9);
      chk("unmapped", 32'h0, rv);
      chk("osc on", 32'h1, osc_regulator_on);
      chk("boost", 32'h1, osc_boost_amp_en);
      $display("t_reset done");
   endtask
   // reserved bits masked, reserved cap codes flagged, every boost code
   task automatic t_osc;
      wr(4'h1, 32'hfffef0af);
      settle;
      rd(4'h1);
      chk("osc rb", 32'h0006f0af, rv);
      chk("osc off", 32'h0, osc_regulator_on);
      chk("xout bad", 32'h1, divider_ratio_bad);
      chk("caps", 32'hf02f, {osc_spare_bits, osc_cap_xout, 2'b00, osc_cap_xin});
      for (i = 0; i < 4; i++) begin
         wr(4'h1, 32'h00012f2f | (i << 14));
         settle;
         chk("boost", 3'h7 >> (3 - i), osc_boost_amp_en);
      end
      chk("caps ok", 32'h0, divider_ratio_bad);
      wr(4'h1, 32'h00012f30);
      settle;
      chk("xin bad", 32'h1, divider_ratio_bad);
      wr(4'h1, `BOCR_OSC_RESET);
      $display("t_osc done");
   endtask
   task automatic t_div;
      wr(4'h2, 32'hffff);
      settle;
      rd(4'h2);
      chk("div rb", 32'hbfff, rv);
      wr(4'h2, 32'h0009);
      settle;
      chk("div off", 32'h0, divider_regulator_on);
      chk("ratio 9", 32'h1, divider_ratio_bad);
      chk("ratio", 32'h9, divider_ratio);
      wr(4'h2, 32'h800a);
      settle;
      chk("ratio 10", 32'h0, divider_ratio_bad);
      $display("t_div done");
   endtask
   // power-down first, then HCSL, LVDS and CMOS at every disabled level with force-off, then the outer disable
   task automatic t_drv;
      wr(4'h3, 32'hff);
      settle;
      rd(4'h3);
      chk("drv rb", 32'h0f, rv);
      chk("pd oe", 32'h0, {out_p_oe, out_n_oe});
      chk("pd act", 32'h2, {driver_powerdown, driver_active});
      for (t = 0; t < 4; t++) for (c = 0; c < 4; c++) if (t != 1) begin
         wr(4'h4, t);
         wr(4'h3, {c[1:0], 2'b10});
         settle;
         chk("type", t, driver_type);
         chk("act off", 32'h0, driver_active);
         case (c)
            0: chk("lvl0", {3'b110, t == 2}, {out_p_oe, out_n_oe, out_p, out_n});
            1: chk("lvl1", 4'b1101, {out_p_oe, out_n_oe, out_p, out_n});
            2: chk("lvl2", 4'b0000, {out_p_oe, out_n_oe, 2'b00});
            default: chk("lvl3", {3'b111, t == 3}, {out_p_oe, out_n_oe, out_p, out_n});
         endcase
      end
      wr(4'h3, 32'h4);
      settle;
      chk("run", 4'b1111, {out_p_oe, out_n_oe, out_p, out_n});
      chk("act on", 32'h1, driver_active);
      divided_clk <= 1'b0;
      wr(4'h4, 32'h2);
      settle;
      chk("run lvds", 4'b1101, {out_p_oe, out_n_oe, out_p, out_n});
      divided_clk <= 1'b1;
      @(posedge mclk);
      ext_disable <= 1'b1;
      settle;
      chk("ext off", 4'b1101, {out_p_oe, out_n_oe, out_p, out_n});
      chk("ext act", 32'h0, driver_active);
      @(posedge mclk);
      ext_disable <= 1'b0;
      $display("t_drv done");
   endtask
   // main sequence
   initial begin
      t_cal(1'b0, 3'h5, 1'b0, 3'h5);
      t_reset;
      t_osc;
      t_div;
      t_drv;
      t_cal(1'b1, 3'h7, 1'b1, `BOCR_CAL_FALLBACK);
      give_verdict;
   end
   // watchdog: about thirty times the expected run
   initial begin
      #400000;
      n_fail++;
      $display("[ERR] watchdog exp done got hang");
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
